//--- include/tcs_consts.svh
// offsets, field positions and reset values of the connection selector
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH
`define TCS_CONN_OFS 8'h00
`define TCS_STAT_OFS 8'h40
`define TCS_F_EN 0
`define TCS_F_DIR 1
`define TCS_F_LOC 4
`define TCS_F_PAR 8
`define TCS_F_ID 16
`define TCS_S_REJ 0
`define TCS_S_MRX 1
`define TCS_S_MTX 2
`define TCS_S_CNT0 8
`define TCS_S_CNT1 12
`define TCS_STN_MIN 3'h1
`define TCS_STN_MAX 3'h4
`define TCS_DIR_UNSET 2'h0
`define TCS_DIR_TX 2'h1
`define TCS_DIR_RX 2'h2
`define TCS_DIR_BOTH 2'h3
`define TCS_CONN_RST 17'h00000
`endif

//--- include/tcs_pkg.sv
// types shared by the telegram connection selector
package tcs_pkg;
   typedef enum logic [1:0] {TCS_UNSET, TCS_SEND, TCS_RECV, TCS_BOTH} tcs_dir_t;
   typedef struct packed {
      logic [7:0] id;
      logic [2:0] partner;
      logic [2:0] local_stn;
      tcs_dir_t dir;
      logic en;
   } tcs_conn_t;
   typedef struct packed {
      logic ch;
      logic [7:0] stn;
      logic [7:0] data;
   } tcs_tel_t;
   typedef struct packed {
      logic [7:0] id;
      logic ch;
      logic [7:0] data;
   } tcs_dlv_t;
endpackage

//--- core/tcs_top.sv
// telegram connection selector: connection table, receive steering, send addressing
// How it works
// [RULE1] a received telegram goes to the receive-capable connection whose local station equals header byte 10.
// [RULE2] a sent telegram carries its connection's partner station in header byte 10.
// [RULE3] configured station numbers outside one to four are rejected; the code checks only a receiver's local and a sender's partner number.
// [RULE4] each channel holds at most eight connections that can send.
// [RULE5] each channel holds at most four receive-capable connections.
// [RULE6] a local station already used on a channel is refused for a second receiving connection there.
// [RULE7] direction code 1 sends only, 2 receives only, 3 does both.
// [RULE8] sending uses only the partner number and receiving only the local number.
// [RULE9] every connection belongs to exactly one of two channels and limits count per channel.
// [RULE10] an enabled connection stays established until reset and cannot be torn down.
// [RULE11] the device alone initiates connections; the partner never sets one up.
// [RULE12] no operating-state messages are ever sent on the link.
// [RULE13] the host picks a connection for each request by its local identifier.
// [RULE14] a connection alone on its channel works without direction or station settings.
// [RULE15] a telegram matching no connection is dropped and flagged as an error.
`include "tcs_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tcs_top #(
   parameter int NCONN = 8
) (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic TX_VALID,
   input wire logic [7:0] TX_ID,
   input wire logic [7:0] TX_DATA,
   output logic TX_READY,
   output logic LINK_TX_VALID,
   output tcs_pkg::tcs_tel_t LINK_TX,
   input wire logic LINK_TX_READY,
   input wire logic LINK_RX_VALID,
   input wire tcs_pkg::tcs_tel_t LINK_RX,
   output logic LINK_RX_READY,
   output logic RX_VALID,
   output tcs_pkg::tcs_dlv_t RX_DLV,
   input wire logic RX_READY
);
   import tcs_pkg::*;
   localparam int NE = 2 * NCONN;
   localparam int IW = $clog2(NE);
   localparam int CW = $clog2(NCONN + 1);

   typedef struct packed {
      tcs_conn_t [NE-1:0] conn;
      logic rej;
      logic miss_rx;
      logic miss_tx;
      logic ack;
      logic [31:0] dat;
      tcs_dlv_t [1:0] buf_q;
      logic [1:0] cnt;
      logic txv;
      tcs_tel_t tx;
   } tcs_st_t;

   tcs_st_t s;
   tcs_st_t next_s;
   logic [NE-1:0] rx_hit;
   logic [NE-1:0] tx_hit;
   logic [NE-1:0] dup_vec;
   logic [NE-1:0] bad_vec;
   logic [NE-1:0] dup_st;
   logic [NE-1:0] en_mask;
   logic [1:0][CW-1:0] est_cnt;
   logic [1:0][CW-1:0] rx_cnt;
   logic [1:0] sole;
   logic [IW-1:0] widx;
   logic [IW-1:0] rx_idx;
   logic [IW-1:0] tx_idx;
   tcs_conn_t wc;
   logic is_conn;
   logic is_stat;
   logic wr_ok;
   logic take;
   logic pop;

   function automatic logic stn_ok(input logic [2:0] v);
      stn_ok = (v >= `TCS_STN_MIN) && (v <= `TCS_STN_MAX);
   endfunction

   function automatic logic [IW-1:0] first(input logic [NE-1:0] v);
      first = '0;
      for (int i = NE - 1; i >= 0; i--) begin
         if (v[i]) begin
            first = IW'(i);
         end
      end
   endfunction

   assign widx = WB_ADR_I[2 +: IW];
   assign is_conn = (WB_ADR_I[7:2] < 6'(NE)); // RULE4
   assign is_stat = (WB_ADR_I == `TCS_STAT_OFS);
   assign wc.en = WB_DAT_I[`TCS_F_EN];
   assign wc.dir = tcs_dir_t'(WB_DAT_I[`TCS_F_DIR +: 2]);
   assign wc.local_stn = WB_DAT_I[`TCS_F_LOC +: 3];
   assign wc.partner = WB_DAT_I[`TCS_F_PAR +: 3];
   assign wc.id = WB_DAT_I[`TCS_F_ID +: 8];

   // per-channel census; the entry index fixes the channel, so no entry is ever on both
   always_comb begin
      est_cnt = '0;
      rx_cnt = '0;
      for (int g = 0; g < NE; g++) begin
         if (s.conn[g].en) begin
            est_cnt[g / NCONN] = est_cnt[g / NCONN] + CW'(1); // RULE9
            if (s.conn[g].dir[1]) begin
               rx_cnt[g / NCONN] = rx_cnt[g / NCONN] + CW'(1);
            end
         end
      end
   end
   assign sole[0] = (est_cnt[0] == CW'(1)); // RULE14
   assign sole[1] = (est_cnt[1] == CW'(1)); // RULE14

   for (genvar g = 0; g < NE; g++) begin : g_ent
      localparam logic CH = (g >= NCONN);
      tcs_conn_t c;
      assign c = s.conn[g];
      assign en_mask[g] = c.en;
      // a sole connection takes every telegram of its channel whatever its settings
      assign rx_hit[g] = c.en && (LINK_RX.ch == CH) &&
         (sole[CH] || (c.dir[1] && (LINK_RX.stn == {5'h00, c.local_stn}))); // RULE1 RULE8
      assign tx_hit[g] = c.en && (c.id == TX_ID) && (sole[CH] || c.dir[0]); // RULE7 RULE13
      assign dup_vec[g] = (IW'(g) != widx) && (CH == widx[IW-1]) && c.en && c.dir[1] &&
         (c.local_stn == wc.local_stn); // RULE6
      assign bad_vec[g] = c.en && ((c.dir[1] && !stn_ok(c.local_stn)) ||
         (c.dir[0] && !stn_ok(c.partner)));
      always_comb begin
         dup_st[g] = 1'b0;
         for (int k = 0; k < NE; k++) begin
            if (k != g && (k / NCONN) == (g / NCONN) && c.en && c.dir[1] &&
               s.conn[k].en && s.conn[k].dir[1] && s.conn[k].local_stn == c.local_stn) begin
               dup_st[g] = 1'b1;
            end
         end
      end
   end

   // unset direction is accepted so a lone connection needs no settings
   assign wr_ok = !(s.conn[widx].en && !wc.en) && // RULE10
      !(wc.en && wc.dir[1] && !stn_ok(wc.local_stn)) && // RULE3
      !(wc.en && wc.dir[0] && !stn_ok(wc.partner)) && // RULE3
      !(wc.en && wc.dir[1] && (|dup_vec)); // RULE6 RULE5
   assign rx_idx = first(rx_hit);
   assign tx_idx = first(tx_hit);
   assign LINK_RX_READY = (s.cnt != 2'h2);
   assign TX_READY = !s.txv || LINK_TX_READY;
   assign take = LINK_RX_VALID && LINK_RX_READY;
   assign pop = RX_READY && (s.cnt != 2'h0);

   always_comb begin
      next_s = s;
      next_s.ack = 1'b0;
      if (WB_CYC_I && WB_STB_I && !s.ack) begin
         next_s.ack = 1'b1;
         next_s.dat = '0;
         if (is_conn) begin
            if (!WB_WE_I) begin
               next_s.dat[`TCS_F_EN] = s.conn[widx].en;
               next_s.dat[`TCS_F_DIR +: 2] = s.conn[widx].dir;
               next_s.dat[`TCS_F_LOC +: 3] = s.conn[widx].local_stn;
               next_s.dat[`TCS_F_PAR +: 3] = s.conn[widx].partner;
               next_s.dat[`TCS_F_ID +: 8] = s.conn[widx].id;
            end else if (&WB_SEL_I[2:0]) begin
               if (wr_ok) begin
                  next_s.conn[widx] = wc;
               end else begin
                  next_s.rej = 1'b1; // RULE3
               end
            end
         end else if (is_stat) begin
            if (!WB_WE_I) begin
               next_s.dat[`TCS_S_REJ] = s.rej;
               next_s.dat[`TCS_S_MRX] = s.miss_rx;
               next_s.dat[`TCS_S_MTX] = s.miss_tx;
               next_s.dat[`TCS_S_CNT0 +: CW] = est_cnt[0];
               next_s.dat[`TCS_S_CNT1 +: CW] = est_cnt[1];
            end else if (WB_SEL_I[0]) begin
               // write one to clear; events below are applied later so they win
               next_s.rej = s.rej && !WB_DAT_I[`TCS_S_REJ];
               next_s.miss_rx = s.miss_rx && !WB_DAT_I[`TCS_S_MRX];
               next_s.miss_tx = s.miss_tx && !WB_DAT_I[`TCS_S_MTX];
            end
         end
      end
      if (pop) begin
         next_s.buf_q[0] = s.buf_q[1];
         next_s.cnt = s.cnt - 2'h1;
      end
      if (take) begin
         if (|rx_hit) begin
            next_s.buf_q[next_s.cnt[0]] = '{s.conn[rx_idx].id, LINK_RX.ch, LINK_RX.data}; // RULE1
            next_s.cnt = next_s.cnt + 2'h1;
         end else begin
            next_s.miss_rx = 1'b1; // RULE15
         end
      end
      if (s.txv && LINK_TX_READY) begin
         next_s.txv = 1'b0;
      end
      // the link carries only host telegrams: no setup from the partner, no state messages
      if (TX_VALID && TX_READY) begin
         if (|tx_hit) begin
            next_s.txv = 1'b1; // RULE11 RULE12
            next_s.tx = '{tx_idx[IW-1], {5'h00, s.conn[tx_idx].partner}, TX_DATA}; // RULE2 RULE8
         end else begin
            next_s.miss_tx = 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s <= '0;
         for (int g = 0; g < NE; g++) begin
            s.conn[g] <= tcs_conn_t'(`TCS_CONN_RST);
         end
      end else begin
         s <= next_s;
      end
   end

   assign WB_ACK_O = s.ack;
   assign WB_DAT_O = s.dat;
   assign LINK_TX_VALID = s.txv;
   assign LINK_TX = s.tx;
   assign RX_VALID = (s.cnt != 2'h0);
   assign RX_DLV = s.buf_q[0];

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   logic [7:0] rx_id_h;
   logic [2:0] tx_par_h;
   assign rx_id_h = s.conn[rx_idx].id;
   assign tx_par_h = s.conn[tx_idx].partner;
   sequence wb_req_s;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence wb_ans_s;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   bus_ack_a: assert property (wb_req_s |=> wb_ans_s)
      else $error("bus request not answered in one cycle");
   rx_route_a: assert property (take && (|rx_hit) && !RX_VALID |=> // RULE1
      RX_VALID && RX_DLV.id == $past(rx_id_h) && RX_DLV.data == $past(LINK_RX.data))
      else $error("received telegram not steered to matching connection");
   tx_stn_a: assert property (TX_VALID && TX_READY && (|tx_hit) |=> // RULE2
      LINK_TX_VALID && LINK_TX.stn == {5'h00, $past(tx_par_h)})
      else $error("sent telegram lacks partner station");
   tx_chan_a: assert property (TX_VALID && TX_READY && (|tx_hit) |=> // RULE9
      LINK_TX.ch == $past(tx_idx[IW-1]))
      else $error("sent telegram on wrong channel");
   stn_range_a: assert property (!(|bad_vec)) // RULE3
      else $error("station number outside one to four stored");
   rx_limit_a: assert property (rx_cnt[0] <= CW'(4) && rx_cnt[1] <= CW'(4)) // RULE5
      else $error("more than four receive connections on a channel");
   dup_stn_a: assert property (!(|dup_st)) // RULE6
      else $error("local station used twice on a channel");
   est_hold_a: assert property ((en_mask & $past(en_mask)) == $past(en_mask)) // RULE10
      else $error("established connection torn down");
   // a host pop in the same cycle may still shrink the buffer; only a push is forbidden
   miss_flag_a: assert property (take && !(|rx_hit) |=> // RULE15
      s.miss_rx && (s.cnt == $past(s.cnt - {1'b0, pop})))
      else $error("unmatched telegram not flagged or delivered");
   buf_stall_a: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DLV))
      else $error("buffered word lost during stall");
endmodule
`default_nettype wire

//--- bench/tcs_link_partner.sv
// far-side link station model
`timescale 1ns/1ns
`default_nettype none
module tcs_link_partner (
   input wire logic clk,
   input wire logic rst_b,
   output logic tx_ready,
   output logic rx_valid,
   output tcs_pkg::tcs_tel_t rx,
   input wire logic rx_ready
);
   import tcs_pkg::*;
   integer seed = 32'h89788359;
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx = '0;
   end
   // random stalls make the device hold its telegram
   always @(posedge clk) tx_ready <= rst_b && ($random(seed) % 2 != 0);
   task automatic send(input tcs_tel_t t);
      @(posedge clk);
      rx_valid <= 1'b1;
      rx <= t;
      // ready is taken as it stood at the edge that accepts the word
      do @(posedge clk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      // a released word must not look like the last one
      rx <= ~t;
   endtask
endmodule
`default_nettype wire

//--- bench/tcs_top_tb_top.sv
// self-checking bench for the connection selector
`timescale 1ns/1ns
`default_nettype none
module tcs_top_tb_top;
   import tcs_pkg::*;
   logic SYS_CLK = 0, RST_B = 0, cyc = 0, we = 0, tx_v = 0, rx_rdy = 0, hold = 0;
   logic [3:0] sel = 4'hF;
   logic [7:0] adr = '0, tx_id = '0, tx_d = '0, d;
   logic [31:0] wdat = '0, rdat, dat_o;
   logic ack, tx_rdy, ltx_v, lp_rdy, lrx_v, lrx_rdy, rx_v;
   tcs_tel_t ltx, lrx;
   tcs_dlv_t dlv;
   integer seed = 32'h89788359, n_errors = 0, num_checks = 0;
   tcs_tel_t tq[$];
   tcs_dlv_t rq[$];
   always #25 SYS_CLK = ~SYS_CLK;
   tcs_top dut_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .WB_CYC_I(cyc), .WB_STB_I(cyc),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .TX_VALID(tx_v), .TX_ID(tx_id), .TX_DATA(tx_d), .TX_READY(tx_rdy),
      .LINK_TX_VALID(ltx_v), .LINK_TX(ltx), .LINK_TX_READY(lp_rdy),
      .LINK_RX_VALID(lrx_v), .LINK_RX(lrx), .LINK_RX_READY(lrx_rdy),
      .RX_VALID(rx_v), .RX_DLV(dlv), .RX_READY(rx_rdy));
   tcs_link_partner u_p (.clk(SYS_CLK), .rst_b(RST_B), .tx_ready(lp_rdy),
      .rx_valid(lrx_v), .rx(lrx), .rx_ready(lrx_rdy));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge SYS_CLK);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      // ack and read data are taken as they stood at this edge
      do @(posedge SYS_CLK); while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, e, rdat);
   endtask
   task automatic rej(input logic [7:0] a, input logic [31:0] v, input logic [31:0] e);
      wb(1'b1, a, v);
      rd("reject status", 8'h40, e);
      wb(1'b1, 8'h40, 32'h1);
   endtask
   function automatic logic [31:0] cw(input logic [7:0] id, input logic [2:0] par,
      input logic [2:0] loc, input logic [1:0] dir);
      return {8'h00, id, 5'h00, par, 1'b0, loc, 1'b0, dir, 1'b1};
   endfunction
   task automatic tx(input logic [7:0] id, input logic [7:0] v);
      @(posedge SYS_CLK);
      tx_v <= 1'b1;
      tx_id <= id;
      tx_d <= v;
      do @(posedge SYS_CLK); while (tx_rdy !== 1'b1);
      tx_v <= 1'b0;
   endtask
   task automatic rx(input logic ch, input logic [7:0] stn, input logic [7:0] id);
      d = $random(seed);
      if (id != 8'h00) rq.push_back({id, ch, d});
      u_p.send({ch, stn, d});
   endtask
   task automatic drain;
      repeat (300) if (tq.size() + rq.size() > 0) @(posedge SYS_CLK);
      chk("queues drained", 32'h0, tq.size() + rq.size());
   endtask
   always @(posedge SYS_CLK) rx_rdy <= !hold && ($random(seed) % 2 != 0);
   always @(posedge SYS_CLK) begin
      if (ltx_v === 1'b1 && lp_rdy === 1'b1) begin
         if (tq.size() == 0) chk("unsolicited telegram", 32'h0, 32'h1);
         else chk("link telegram", {15'h0, tq.pop_front()}, {15'h0, ltx});
      end
      if (rx_v === 1'b1 && rx_rdy === 1'b1) begin
         if (rq.size() == 0) chk("stray delivery", 32'h0, 32'h1);
         else chk("delivery", {15'h0, rq.pop_front()}, {15'h0, dlv});
      end
   end
   task automatic conclude;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #2000000;
      n_errors++;
      conclude;
   end
   initial begin
      repeat (4) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      rd("status", 8'h40, 32'h0);
      rd("conn0", 8'h00, 32'h0);
      rd("unmapped", 8'h80, 32'h0);
      $display("test reset done");
      wb(1'b1, 8'h00, cw(8'h11, 3'h3, 3'h0, TCS_SEND));
      wb(1'b1, 8'h04, cw(8'h22, 3'h0, 3'h2, TCS_RECV));
      wb(1'b1, 8'h08, cw(8'h33, 3'h4, 3'h1, TCS_BOTH));
      wb(1'b1, 8'h20, cw(8'h44, 3'h0, 3'h0, TCS_UNSET));
      rd("conn2", 8'h08, cw(8'h33, 3'h4, 3'h1, TCS_BOTH));
      rd("counts", 8'h40, 32'h1300);
      rej(8'h0C, cw(8'h55, 3'h0, 3'h5, TCS_RECV), 32'h1301);
      rej(8'h0C, cw(8'h55, 3'h0, 3'h0, TCS_SEND), 32'h1301);
      rej(8'h0C, cw(8'h55, 3'h0, 3'h2, TCS_RECV), 32'h1301);
      rej(8'h00, 32'h0, 32'h1301);
      sel <= 4'h1;
      wb(1'b1, 8'h0C, cw(8'h55, 3'h0, 3'h3, TCS_RECV));
      sel <= 4'hF;
      rd("partial lanes", 8'h0C, 32'h0);
      $display("test config done");
      repeat (3) begin
         d = $random(seed);
         tq.push_back({1'b0, 8'h03, d});
         tx(8'h11, d);
         tq.push_back({1'b0, 8'h04, d});
         tx(8'h33, d);
         tq.push_back({1'b1, 8'h00, d});
         tx(8'h44, d);
         tx(8'h22, d);
         rx(1'b0, 8'h02, 8'h22);
         rx(1'b0, 8'h01, 8'h33);
         rx(1'b0, 8'h03, 8'h00);
         rx(1'b1, 8'h07, 8'h44);
      end
      drain;
      rd("flags", 8'h40, 32'h1306);
      wb(1'b1, 8'h40, 32'h7);
      $display("test traffic done");
      wb(1'b1, 8'h0C, cw(8'h66, 3'h0, 3'h3, TCS_RECV));
      wb(1'b1, 8'h10, cw(8'h77, 3'h1, 3'h4, TCS_BOTH));
      rej(8'h14, cw(8'h88, 3'h0, 3'h1, TCS_RECV), 32'h1501);
      hold = 1'b1;
      fork
         begin
            rx(1'b0, 8'h03, 8'h66);
            rx(1'b0, 8'h04, 8'h77);
            rx(1'b0, 8'h02, 8'h22);
         end
      join_none
      repeat (20) @(posedge SYS_CLK);
      chk("buffer full", 32'h0, {31'h0, lrx_rdy});
      hold = 1'b0;
      drain;
      $display("test buffer done");
      conclude;
   end
endmodule
`default_nettype wire
